/* rtl/slsw_pkg.sv */
/*
  slsw_pkg: constants, register map and carrier types for the serial load switch block.
  assumes: one 250 MHz system clock; serial link sampled from pins.
*/
// Functional notes
// [RULE1] while select low, each shift clock rising edge shifts serial_in into register.
// [RULE2] controller sends exactly 8 or 16 bits per select-low frame.
// [RULE3] control bit one turns its channel on, zero turns it off.
// [RULE4] controller raises select only after the last bit is clocked.
// [RULE5] select rising edge copies six latest shifted bits to output buffer.
// [RULE6] select rising edge releases serial_out to high impedance while deselected.
// [RULE7] select rising edge resumes live fault register tracking.
// [RULE8] captured fault flags xor into leading shift bits, inverting outgoing data; code xors them into the lowest seven shift bits, sent last.
// [RULE9] fault word: open/short flags bits 0 to 5, over-temperature bit 6.
// [RULE10] while deselected, fault bits follow detectors without the shift clock.
// [RULE11] faults captured into serial path at select falling edge.
// [RULE12] faults arising during select low are not captured this frame.
// [RULE13] serial_out updates on rising shift clock edges while selected.
// [RULE14] serial lines are ignored unless select is low.
// [RULE15] overcurrent on enabled channel forces low duty pwm while fault persists.
// [RULE16] reset clears output buffer and shift register; all channels off.
// [RULE17] over-battery lockout holds all channels off.
package slsw_pkg;
  localparam int NCH = 6;
  localparam int FW = 7;
  localparam int SHW = 16;
  localparam int OVT_BIT = 6;
  localparam logic [31:0] A_CTRL = 32'h0000_0000;
  localparam logic [31:0] A_FAULT = 32'h0000_0004;
  localparam logic [31:0] A_IRQ_STAT = 32'h0000_0008;
  localparam logic [31:0] A_IRQ_MASK = 32'h0000_000c;
  localparam logic [31:0] A_PWM = 32'h0000_0010;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;
  localparam int IRQ_W = 3;
  localparam int IRQ_LATCH = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_LOCK = 2;
  localparam logic [7:0] PWM_PERIOD_RST = 8'hff;
  localparam logic [7:0] PWM_ON_RST = 8'h08;
  localparam int PWM_PRESCALE = 64;
  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic serial_in;
  } slsw_link_s;
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_WAIT = 3'b010,
    RD_RESP = 3'b100
  } slsw_rd_e;
endpackage

/* rtl/slsw_serial.sv */
/*
  slsw_serial: serial shift path, fault capture and serial_out drive.
  assumes: link signals already synchronised to clock_i.
*/
`timescale 1ns/1ps
module slsw_serial
  import slsw_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire slsw_link_s link_i,
  input wire logic [FW-1:0] fault_now_i,
  output logic latch_o,
  output logic [NCH-1:0] latch_data_o,
  output logic serial_out_o,
  output logic serial_out_oe_b_o,
  output logic [FW-1:0] fault_reg_o
);
  logic sel_d, sclk_d;
  logic [SHW-1:0] shreg, next_shreg;
  logic [FW-1:0] fault_reg, next_fault_reg;
  logic so, next_so, oe_b, next_oe_b;
  logic latch, next_latch;
  logic [NCH-1:0] ldata, next_ldata;
  logic sel_fall, sel_rise, sclk_rise;

  assign sel_fall = sel_d & ~link_i.sel_n;
  assign sel_rise = ~sel_d & link_i.sel_n;
  assign sclk_rise = ~sclk_d & link_i.sclk & ~link_i.sel_n;  // [RULE14]

  always_comb
  begin
    next_shreg = shreg;
    next_fault_reg = fault_reg;
    next_so = so;
    next_oe_b = oe_b;
    next_latch = 1'b0;
    next_ldata = ldata;
    if (link_i.sel_n)
      next_fault_reg = fault_now_i;  // [RULE10] [RULE7]
    if (sel_fall)
    begin
      next_shreg = shreg ^ {{(SHW-FW){1'b0}}, fault_reg};  // [RULE11] [RULE8] [RULE9]
      next_oe_b = 1'b0;
      next_so = next_shreg[SHW-1];
    end
    else if (sclk_rise)
    begin
      next_shreg = {shreg[SHW-2:0], link_i.serial_in};  // [RULE1] [RULE12]
      next_so = shreg[SHW-2];  // [RULE13]
    end
    if (sel_rise)
    begin
      next_latch = 1'b1;
      next_ldata = shreg[NCH-1:0];  // [RULE5]
      next_oe_b = 1'b1;  // [RULE6]
      next_so = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      sel_d <= 1'b1;
      sclk_d <= 1'b0;
      shreg <= '0;  // [RULE16]
      fault_reg <= '0;
      so <= 1'b0;
      oe_b <= 1'b1;
      latch <= 1'b0;
      ldata <= '0;
    end
    else
    begin
      sel_d <= link_i.sel_n;
      sclk_d <= link_i.sclk;
      shreg <= next_shreg;
      fault_reg <= next_fault_reg;
      so <= next_so;
      oe_b <= next_oe_b;
      latch <= next_latch;
      ldata <= next_ldata;
    end
  end

  assign latch_o = latch;
  assign latch_data_o = ldata;
  assign serial_out_o = so;
  assign serial_out_oe_b_o = oe_b;
  assign fault_reg_o = fault_reg;
endmodule // slsw_serial

/* rtl/slsw_top.sv */
/*
  slsw_top: six channel load switch control with serial link, pwm fault mode,
  interrupt status and an axi4-lite register slave.
  assumes: link pins and detector inputs are asynchronous to clock_i.
*/
`timescale 1ns/1ps
module slsw_top
  import slsw_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic sel_b_i,
  input wire logic sclk_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_b_o,
  input wire logic [NCH-1:0] load_fault_i,
  input wire logic [NCH-1:0] overcurrent_i,
  input wire logic overtemp_i,
  input wire logic overbattery_i,
  output logic [NCH-1:0] load_switch_out_o,
  output logic irq_o,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int SW = 3 + NCH + NCH + 2;
  logic [SW-1:0] s1, s2;
  slsw_link_s link;
  logic [NCH-1:0] lf_s, oc_s;
  logic ot_s, ob_s;
  logic ser_latch, so_w, oe_w;
  logic [NCH-1:0] ldata;
  logic [FW-1:0] freg;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      s1 <= {1'b1, {(SW-1){1'b0}}};
      s2 <= {1'b1, {(SW-1){1'b0}}};
    end
    else
    begin
      s1 <= {sel_b_i, sclk_i, serial_in_i, load_fault_i, overcurrent_i, overtemp_i, overbattery_i};
      s2 <= s1;
    end
  end
  assign link = '{sel_n: s2[SW-1], sclk: s2[SW-2], serial_in: s2[SW-3]};
  assign lf_s = s2[2*NCH+1:NCH+2];
  assign oc_s = s2[NCH+1:2];
  assign ot_s = s2[1];
  assign ob_s = s2[0];

  slsw_serial u_ser (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .link_i(link),
    .fault_now_i({ot_s, lf_s | oc_s}),
    .latch_o(ser_latch),
    .latch_data_o(ldata),
    .serial_out_o(so_w),
    .serial_out_oe_b_o(oe_w),
    .fault_reg_o(freg)
  );

  // output buffer, pwm and lockout
  logic [NCH-1:0] obuf, next_obuf;
  logic [7:0] pwm_period, pwm_on;
  logic [5:0] pre, next_pre;
  logic [7:0] pcnt, next_pcnt;
  logic pwm_hi;
  logic [NCH-1:0] sw, next_sw;
  logic [IRQ_W-1:0] istat, next_istat, imask;
  logic irq, next_irq;
  logic ob_d, next_ob_d;
  logic [FW-1:0] freg_d, next_freg_d;
  logic wr_ctrl, wr_stat, wr_mask, wr_pwm;
  logic [31:0] wdat;

  assign pwm_hi = (pcnt < pwm_on);
  always_comb
  begin
    next_obuf = obuf;
    if (ser_latch)
      next_obuf = ldata;  // [RULE5]
    else if (wr_ctrl)
      next_obuf = wdat[NCH-1:0];
    next_pre = pre + 6'h01;
    next_pcnt = pcnt;
    if (pre == 6'(PWM_PRESCALE - 1))
    begin
      next_pre = 6'h00;
      next_pcnt = (pcnt >= pwm_period) ? 8'h00 : pcnt + 8'h01;
    end
    for (int i = 0; i < NCH; i++)
      next_sw[i] = obuf[i] & ~ob_s & (~oc_s[i] | pwm_hi);  // [RULE3] [RULE15] [RULE17]
    next_ob_d = ob_s;
    next_freg_d = freg;
    next_istat = istat;
    if (wr_stat)
      next_istat = istat & ~wdat[IRQ_W-1:0];
    if (ser_latch)
      next_istat[IRQ_LATCH] = 1'b1;
    if (|(freg & ~freg_d))
      next_istat[IRQ_FAULT] = 1'b1;
    if (ob_s & ~ob_d)
      next_istat[IRQ_LOCK] = 1'b1;
    next_irq = |(next_istat & imask);
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      obuf <= '0;  // [RULE16]
      pre <= 6'h00;
      pcnt <= 8'h00;
      sw <= '0;
      istat <= '0;
      irq <= 1'b0;
      ob_d <= 1'b0;
      freg_d <= '0;
    end
    else
    begin
      obuf <= next_obuf;
      pre <= next_pre;
      pcnt <= next_pcnt;
      sw <= next_sw;
      istat <= next_istat;
      irq <= next_irq;
      ob_d <= next_ob_d;
      freg_d <= next_freg_d;
    end
  end

  // axi4-lite write path
  logic aw_got, w_got, next_aw_got, next_w_got;
  logic [31:0] awa, next_awa, next_wdat;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic do_wr;
  logic awrdy, wrdy;
  logic [IRQ_W-1:0] next_imask;
  logic [7:0] next_pwm_period, next_pwm_on;

  assign do_wr = aw_got & w_got & ~bvalid;
  assign wr_ctrl = do_wr & (awa == A_CTRL);
  assign wr_stat = do_wr & (awa == A_IRQ_STAT);
  assign wr_mask = do_wr & (awa == A_IRQ_MASK);
  assign wr_pwm = do_wr & (awa == A_PWM);
  always_comb
  begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_awa = awa;
    next_wdat = wdat;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_imask = imask;
    next_pwm_period = pwm_period;
    next_pwm_on = pwm_on;
    if (s_axi_awvalid & ~aw_got)
    begin
      next_aw_got = 1'b1;
      next_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~w_got)
    begin
      next_w_got = 1'b1;
      next_wdat = s_axi_wdata;
    end
    if (do_wr)
    begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wr_ctrl | wr_stat | wr_mask | wr_pwm | awa == A_FAULT) ? RESP_OK : RESP_DEC;
      if (wr_mask)
        next_imask = wdat[IRQ_W-1:0];
      if (wr_pwm)
      begin
        next_pwm_period = wdat[7:0];
        next_pwm_on = wdat[15:8];
      end
    end
    if (bvalid & s_axi_bready)
      next_bvalid = 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awrdy <= 1'b1;
      wrdy <= 1'b1;
      awa <= '0;
      wdat <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OK;
      imask <= '0;
      pwm_period <= PWM_PERIOD_RST;
      pwm_on <= PWM_ON_RST;
    end
    else
    begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awrdy <= ~next_aw_got;
      wrdy <= ~next_w_got;
      awa <= next_awa;
      wdat <= next_wdat;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      imask <= next_imask;
      pwm_period <= next_pwm_period;
      pwm_on <= next_pwm_on;
    end
  end

  // axi4-lite read path
  slsw_rd_e rst_q, next_rst_q;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic ardy, rvld;
  always_comb
  begin
    next_rst_q = rst_q;
    next_rdata = rdata;
    next_rresp = rresp;
    unique case (rst_q)
      RD_IDLE:
        if (s_axi_arvalid)
        begin
          next_rst_q = RD_RESP;
          next_rresp = RESP_OK;
          case (s_axi_araddr)
            A_CTRL: next_rdata = {26'h0, obuf};
            A_FAULT: next_rdata = {25'h0, freg};
            A_IRQ_STAT: next_rdata = {29'h0, istat};
            A_IRQ_MASK: next_rdata = {29'h0, imask};
            A_PWM: next_rdata = {16'h0, pwm_on, pwm_period};
            default:
            begin
              next_rdata = 32'h0;
              next_rresp = RESP_DEC;
            end
          endcase
        end
      RD_WAIT:
        next_rst_q = RD_RESP;
      RD_RESP:
        if (s_axi_rready)
          next_rst_q = RD_IDLE;
      default:
        next_rst_q = RD_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      rst_q <= RD_IDLE;
      ardy <= 1'b1;
      rvld <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OK;
    end
    else
    begin
      rst_q <= next_rst_q;
      ardy <= (next_rst_q == RD_IDLE);
      rvld <= (next_rst_q == RD_RESP);
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_awready = awrdy;
  assign s_axi_wready = wrdy;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = ardy;
  assign s_axi_rvalid = rvld;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign serial_out_o = so_w;
  assign serial_out_oe_b_o = oe_w;
  assign load_switch_out_o = sw;
  assign irq_o = irq;
endmodule // slsw_top

/* sim/slsw_sva.sv */
/* slsw_sva: port checker for slsw_top.
   assumes: bound to slsw_top, one clock domain, sync active low reset. */
`timescale 1ns/1ps
module slsw_sva
  import slsw_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic sel_b_i,
  input wire logic sclk_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_b_o,
  input wire logic overbattery_i,
  input wire logic [NCH-1:0] load_switch_out_o,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence deselected;
    sel_b_i [*6];
  endsequence
  sequence selected;
    !sel_b_i [*6];
  endsequence
  a_oe_released: assert property (deselected |-> serial_out_oe_b_o) else $error("serial out driven");
  a_out_quiet: assert property (serial_out_oe_b_o |-> !serial_out_o) else $error("released out not 0");
  a_oe_driven: assert property (selected |-> !serial_out_oe_b_o) else $error("serial out not driven");
  a_out_steady: assert property ((!sel_b_i && sclk_i) [*6] |=> $stable(serial_out_o))
    else $error("serial out moved");
  a_lockout_off: assert property (overbattery_i [*6] |-> load_switch_out_o == '0)
    else $error("switch on in lockout");
  a_wr_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
  a_wr_busy: assert property (wr_take |=> !s_axi_awready && !s_axi_wready) else $error("ready during write");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during read");
endmodule // slsw_sva
bind slsw_top slsw_sva i_sva (.clock_i, .rst_b_i, .sel_b_i, .sclk_i, .serial_out_o, .serial_out_oe_b_o,
  .overbattery_i, .load_switch_out_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

/* sim/slsw_host.sv */
/* slsw_host: serial bus controller model, 64 ns shift clock.
   assumes: tasks are called from code aligned to a rising clock_i edge. */
`timescale 1ns/1ps
module slsw_host
(
  input wire logic clock_i,
  input wire logic serial_out_i,
  input wire logic serial_out_oe_b_i,
  output logic sel_b_o,
  output logic sclk_o,
  output logic serial_in_o
);
  initial
  begin
    sel_b_o = 1'b1;
    sclk_o = 1'b0;
    serial_in_o = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge clock_i);
  endtask
  task automatic frame(input int n, input logic [15:0] d, output logic [15:0] q);
    q = '0;
    sel_b_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in_o <= d[i];
      sclk_o <= 1'b0;
      half();
      q = {q[14:0], serial_out_oe_b_i ? 1'bx : serial_out_i};
      sclk_o <= 1'b1;
      half();
    end
    sclk_o <= 1'b0;
    half();
    sel_b_o <= 1'b1;
    serial_in_o <= 1'b0;
    half();
  endtask
  // shift clock wiggled while deselected
  task automatic noise();
    serial_in_o <= 1'b1;
    repeat (4)
    begin
      half();
      sclk_o <= ~sclk_o;
    end
    serial_in_o <= 1'b0;
    half();
  endtask
endmodule // slsw_host

/* sim/slsw_top_bench.sv */
/* slsw_top_bench: self-checking bench for slsw_top.
   assumes: slsw_host drives the link; axi4-lite tasks reach the registers. */
`timescale 1ns/1ps
module slsw_top_bench;
  import slsw_pkg::*;
  logic clock_i, rst_b_i, sel_b, sclk, serial_in, sout, soe_b, otemp, obat, irq;
  logic [NCH-1:0] lf, oc, sw;
  logic [31:0] awaddr, wdata, araddr, rdata, v, seed;
  logic aw, awr, wv, wr_r, bv, br, ar, arr, rv, rr;
  logic [1:0] bresp, rresp, r;
  logic [15:0] d, q, sh, x;
  logic [6:0] f;
  int n_errors, num_checks, cnt, n;
  slsw_host i_host (.clock_i(clock_i), .serial_out_i(sout), .serial_out_oe_b_i(soe_b), .sel_b_o(sel_b),
    .sclk_o(sclk), .serial_in_o(serial_in));
  slsw_top i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .sel_b_i(sel_b), .sclk_i(sclk), .serial_in_i(serial_in),
    .serial_out_o(sout), .serial_out_oe_b_o(soe_b), .load_fault_i(lf), .overcurrent_i(oc),
    .overtemp_i(otemp), .overbattery_i(obat), .load_switch_out_o(sw), .irq_o(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr),
    .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] ret_exp(input logic [15:0] s, input logic [6:0] fl, input int nb);
    return (s ^ fl) >> (16 - nb);
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] dat);
    @(posedge clock_i);
    {awaddr, wdata, aw, wv, br} <= {a, dat, 3'b111};
    do
    begin
      @(posedge clock_i);
      if (awr) aw <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end
    while (!bv);
    r = bresp;
    br <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clock_i);
    {araddr, ar, rr} <= {a, 2'b11};
    do
    begin
      @(posedge clock_i);
      if (arr) ar <= 1'b0;
    end
    while (!rv);
    {v, r} = {rdata, rresp};
    rr <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    end_of_test();
  end
  initial
  begin
    seed = 32'ha0a49a23;
    {rst_b_i, lf, oc, otemp, obat, awaddr, wdata, araddr, aw, wv, br, ar, rr} = '0;
    {sh, n_errors, num_checks} = '0;
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    chk(sw, 0);
    rd(A_IRQ_MASK);
    chk(v, 0);
    rd(A_PWM);
    chk(v, {PWM_ON_RST, PWM_PERIOD_RST});
    rd(32'h40);
    chk(r, RESP_DEC);
    wr(32'h44, 32'h1);
    chk(r, RESP_DEC);
    wr(A_IRQ_MASK, 32'h1 << IRQ_LATCH);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      d = 16'($random(seed));
      f = 7'($random(seed));
      {otemp, lf} <= f;
      repeat (10) @(posedge clock_i);
      rd(A_FAULT);
      chk(v, f);
      if (i == 2) i_host.noise();
      n = (i == 3) ? 8 : 16;
      fork
        i_host.frame(n, d, q);
        begin
          repeat (40) @(posedge clock_i);
          lf <= ~f[5:0];
        end
      join
      chk(q, ret_exp(sh, f, n));
      x = sh ^ f;
      sh = 16'((x << n) | (d & ((32'h1 << n) - 1)));
      repeat (10) @(posedge clock_i);
      chk(sw, sh[5:0]);
      chk(soe_b, 1);
      chk(irq, 1);
      rd(A_FAULT);
      chk(v, {f[6], ~f[5:0]});
      wr(A_IRQ_STAT, 32'h1 << IRQ_LATCH);
      repeat (3) @(posedge clock_i);
      chk(irq, 0);
    end
    $display("test frames done");
    wr(A_CTRL, 32'h3f);
    obat <= 1'b1;
    repeat (10) @(posedge clock_i);
    chk(sw, 0);
    chk(irq, 0);
    obat <= 1'b0;
    wr(A_IRQ_MASK, 32'h1 << IRQ_LOCK);
    repeat (10) @(posedge clock_i);
    chk(sw, 6'h3f);
    chk(irq, 1);
    wr(A_IRQ_STAT, 32'h1 << IRQ_LOCK);
    repeat (3) @(posedge clock_i);
    chk(irq, 0);
    $display("test lockout done");
    wr(A_CTRL, 32'h1);
    wr(A_PWM, 32'h0103);
    oc <= 6'h1;
    cnt = 0;
    repeat (1024)
    begin
      @(posedge clock_i);
      cnt += sw[0];
    end
    chk(cnt >= 128 && cnt <= 384, 1);
    oc <= 6'h0;
    repeat (10) @(posedge clock_i);
    chk(sw, 6'h1);
    $display("test pwm done");
    end_of_test();
  end
endmodule // slsw_top_bench
